/* File: core/swr_pkg.sv */
// Package for the sleep, wake and reset-cause block: register map, fields, timing.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package swr_pkg;
  // Register byte offsets
  localparam logic [7:0] SWR_OPTIONS_OFF = 8'h00;
  localparam logic [7:0] SWR_STATUS_OFF = 8'h04;
  localparam logic [7:0] SWR_IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] SWR_IRQ_MASK_OFF = 8'h0C;
  localparam logic [7:0] SWR_CTRL_OFF = 8'h10;
  // Option register layout and reset value
  localparam logic [7:0] SWR_OPTIONS_RST = 8'h3F;
  localparam logic [7:0] SWR_OPTIONS_MASK = 8'h3F;
  localparam int SWR_OPT_ASSIGN_BIT = 3;
  localparam int SWR_OPT_RATIO_LSB = 0;
  // Status bit positions
  localparam int SWR_ST_TIMEOUT_BIT = 4;
  localparam int SWR_ST_PWRDN_BIT = 3;
  localparam int SWR_ST_ASLEEP_BIT = 0;
  // Interrupt event bits
  localparam int SWR_EV_WDT = 0;
  localparam int SWR_EV_WAKE = 1;
  localparam int SWR_EV_SLEEP = 2;
  localparam int SWR_EV_W = 3;
  // Control register bits: sleep command, clear-watchdog command
  localparam int SWR_CTRL_SLEEP_BIT = 0;
  localparam int SWR_CTRL_CLRWD_BIT = 1;
  // Watchdog base period
  localparam int SWR_CLK_MHZ = 100;
  localparam int SWR_WDT_PERIOD_US = 18000;
  localparam int SWR_WDT_CYCLES = SWR_WDT_PERIOD_US * SWR_CLK_MHZ;
  // Reset pulse length in cycles, minus one
  localparam logic [3:0] SWR_RST_PULSE = 4'h4;
  // Power states
  typedef enum logic [1:0] {
    SWR_RUN = 2'b00,
    SWR_SLEEP = 2'b01,
    SWR_RESET = 2'b10
  } swr_state_e;
endpackage : swr_pkg

/* File: core/swr_axil.sv */
// AXI4-Lite slave front end: produces one-cycle write and read strobes.
// Assumes one clock; read data is supplied combinationally by the parent.
`timescale 1ns/1ps
module swr_axil (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [7:0] s_awaddr, // Write address
  input wire logic s_awvalid, // Write address valid
  output logic s_awready, // Write address ready
  input wire logic [31:0] s_wdata, // Write data
  input wire logic [3:0] s_wstrb, // Write strobes
  input wire logic s_wvalid, // Write data valid
  output logic s_wready, // Write data ready
  output logic [1:0] s_bresp, // Write response
  output logic s_bvalid, // Write response valid
  input wire logic s_bready, // Write response ready
  input wire logic [7:0] s_araddr, // Read address
  input wire logic s_arvalid, // Read address valid
  output logic s_arready, // Read address ready
  output logic [31:0] s_rdata, // Read data
  output logic [1:0] s_rresp, // Read response
  output logic s_rvalid, // Read valid
  input wire logic s_rready, // Read ready
  output logic wr_en, // Write strobe
  output logic [7:0] wr_addr, // Write address held
  output logic [31:0] wr_data, // Write data held
  output logic [3:0] wr_strb, // Write strobes held
  input wire logic wr_err, // Write address unmapped
  output logic rd_en, // Read strobe
  output logic [7:0] rd_addr, // Read address held
  input wire logic [31:0] rd_data, // Read data from parent
  input wire logic rd_err // Read address unmapped
);
  logic aw_have_r;
  logic w_have_r;
  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        wr_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_r <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (wr_en) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
    end
  end
  assign s_awready = !aw_have_r && !s_bvalid;
  assign s_wready = !w_have_r && !s_bvalid;
  assign wr_en = aw_have_r && w_have_r;
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
    end else if (wr_en) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_err ? 2'b10 : 2'b00;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end
  // Read channel: address then data one cycle later
  logic ar_have_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_r <= 1'b0;
      rd_addr <= 8'h00;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'b00;
    end else begin
      if (s_arvalid && s_arready) begin
        ar_have_r <= 1'b1;
        rd_addr <= s_araddr;
      end
      if (rd_en) begin
        ar_have_r <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_data;
        s_rresp <= rd_err ? 2'b10 : 2'b00;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
  assign s_arready = !ar_have_r && !s_rvalid;
  assign rd_en = ar_have_r;
endmodule : swr_axil

/* File: core/swr_wdt.sv */
// Watchdog base counter and 8-bit postscaler.
// Assumes a single clock; clears arrive as one-cycle pulses.
`timescale 1ns/1ps
module swr_wdt #(
  parameter int BASE_CYCLES = 1800000 // Cycles per base time-out
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic enable, // Watchdog running
  input wire logic clear, // Clear counter and postscaler
  input wire logic use_scaler, // Postscaler assigned to watchdog
  input wire logic [2:0] ratio, // Postscale ratio select
  output logic timeout, // One-cycle time-out pulse
  output logic [31:0] count // Base counter value
);
  logic [7:0] scaler_r;
  logic base_tick;
  logic [7:0] limit;
  assign base_tick = (count == 32'(BASE_CYCLES - 1));
  // Ratio 1:1 .. 1:128 from the three select bits
  assign limit = 8'((9'h001 << ratio) - 9'h001);
  // Base counter
  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !enable || base_tick) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end
  // Postscaler and time-out
  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !enable) begin
      scaler_r <= 8'h00;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (base_tick) begin
        if (!use_scaler || scaler_r == limit) begin
          scaler_r <= 8'h00;
          timeout <= 1'b1;
        end else begin
          scaler_r <= scaler_r + 8'h01;
        end
      end
    end
  end
endmodule : swr_wdt

/* File: core/swr_top.sv */
// Sleep, wake-up and reset-cause control with watchdog and register access.
// Assumes synchronous master-clear pin input and one-cycle decoder commands.
// Behaviour
// - Sleep is entered only on the sleep command, from the core or the control register.
// - Entering sleep clears watchdog, sets timeout flag, clears powerdown flag, stops oscillator.
// - While asleep every I/O pin holds its prior drive state.
// - Watchdog reset is internal only; master-clear pin is never driven.
// - Wake on master-clear active level or enabled watchdog time-out.
// - Either wake event gives full device reset, not resumption.
// - Any watchdog time-out clears the active-low timeout flag.
// - Powerdown flag set at power-up, cleared by sleep command.
// - Watchdog counter cleared on every wake from sleep.
// - Option register loads 3F on power-on, master-clear and watchdog reset.
// - Option low nibble selects postscaler assignment and ratio.
// - Base time-out 18 ms, extended by postscaler up to 1:128.
// - Clear-watchdog command clears counter and postscaler.
// - Watchdog enable config bit low disables watchdog completely.
`timescale 1ns/1ps
module swr_top
  import swr_pkg::*;
#(
  parameter int WDT_CYCLES = swr_pkg::SWR_WDT_CYCLES, // Base watchdog period in cycles
  parameter int IO_W = 8 // Number of I/O pins
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Power-on reset, sync, active low
  input wire logic master_clear_pin_n, // External reset pin, active low
  input wire logic sleep_instr, // Sleep command pulse
  input wire logic clear_watchdog_instr, // Clear-watchdog command pulse
  input wire logic watchdog_enable_cfg, // Config bit, 1 enables watchdog
  input wire logic [IO_W-1:0] io_out_core, // Core pin output values
  input wire logic [IO_W-1:0] io_oe_core, // Core pin output enables
  output logic [IO_W-1:0] io_out, // Pin output values
  output logic [IO_W-1:0] io_oe, // Pin output enables
  output logic osc_drive_en, // Oscillator driver enable
  output logic device_reset, // Internal device reset
  output logic asleep, // Sleep state
  output logic timeout_flag_n, // Time-out status flag
  output logic powerdown_flag_n, // Power-down status flag
  output logic [7:0] timer_prescale_options, // Option register value
  output logic irq, // Interrupt level
  input wire logic [7:0] s_awaddr, // Write address
  input wire logic s_awvalid, // Write address valid
  output logic s_awready, // Write address ready
  input wire logic [31:0] s_wdata, // Write data
  input wire logic [3:0] s_wstrb, // Write strobes
  input wire logic s_wvalid, // Write data valid
  output logic s_wready, // Write data ready
  output logic [1:0] s_bresp, // Write response
  output logic s_bvalid, // Write response valid
  input wire logic s_bready, // Write response ready
  input wire logic [7:0] s_araddr, // Read address
  input wire logic s_arvalid, // Read address valid
  output logic s_arready, // Read address ready
  output logic [31:0] s_rdata, // Read data
  output logic [1:0] s_rresp, // Read response
  output logic s_rvalid, // Read valid
  input wire logic s_rready // Read ready
);
  import swr_pkg::*;
  swr_state_e state_r;
  logic master_clear_pin_n_s1_r, master_clear_pin_n_s2_r;
  logic wr_en, rd_en, wr_err, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic wd_timeout, wd_clear, wd_en;
  logic [31:0] wd_count;
  logic [3:0] rst_cnt_r;
  logic [IO_W-1:0] io_out_hold_r, io_oe_hold_r;
  logic [SWR_EV_W-1:0] irq_stat_r, irq_mask_r, ev;
  logic sw_sleep, sw_clrwd, do_sleep, do_clrwd, wake, master_clear_pin_n_act;
  logic stat_rd;

  // Master-clear pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_clear_pin_n_s1_r <= 1'b1;
      master_clear_pin_n_s2_r <= 1'b1;
    end else begin
      master_clear_pin_n_s1_r <= master_clear_pin_n;
      master_clear_pin_n_s2_r <= master_clear_pin_n_s1_r;
    end
  end
  assign master_clear_pin_n_act = !master_clear_pin_n_s2_r;

  // Register bus front end
  swr_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Software command strobes from the control register
  assign sw_sleep = wr_en && wr_addr == SWR_CTRL_OFF && wr_strb[0]
                    && wr_data[SWR_CTRL_SLEEP_BIT];
  assign sw_clrwd = wr_en && wr_addr == SWR_CTRL_OFF && wr_strb[0]
                    && wr_data[SWR_CTRL_CLRWD_BIT];
  // A reset request in the same cycle wins over the sleep command
  assign do_sleep = (sleep_instr || sw_sleep) && state_r == SWR_RUN
                    && !master_clear_pin_n_act && !wd_timeout;
  assign do_clrwd = (clear_watchdog_instr || sw_clrwd) && state_r == SWR_RUN;
  assign wd_en = watchdog_enable_cfg;
  assign wake = state_r == SWR_SLEEP && (master_clear_pin_n_act || wd_timeout);
  // Counter cleared by clear command, sleep entry, wake and any reset
  assign wd_clear = do_clrwd || do_sleep || wake || state_r == SWR_RESET;

  // Watchdog counter and postscaler
  swr_wdt #(
    .BASE_CYCLES(WDT_CYCLES)
  ) u_wdt (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(wd_en),
    .clear(wd_clear),
    .use_scaler(timer_prescale_options[SWR_OPT_ASSIGN_BIT]),
    .ratio(timer_prescale_options[SWR_OPT_RATIO_LSB +: 3]),
    .timeout(wd_timeout),
    .count(wd_count)
  );

  // Power state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SWR_RESET;
      rst_cnt_r <= SWR_RST_PULSE;
    end else begin
      case (state_r)
        SWR_RUN: begin
          if (master_clear_pin_n_act || wd_timeout) begin
            state_r <= SWR_RESET;
            rst_cnt_r <= SWR_RST_PULSE;
          end else if (do_sleep) begin
            state_r <= SWR_SLEEP;
          end
        end
        SWR_SLEEP: begin
          if (wake) begin
            state_r <= SWR_RESET;
            rst_cnt_r <= SWR_RST_PULSE;
          end
        end
        default: begin
          if (master_clear_pin_n_act) begin
            rst_cnt_r <= SWR_RST_PULSE;
          end else if (rst_cnt_r == 4'h0) begin
            state_r <= SWR_RUN;
          end else begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
          end
        end
      endcase
    end
  end
  assign asleep = state_r == SWR_SLEEP;
  assign device_reset = state_r == SWR_RESET;
  assign osc_drive_en = state_r != SWR_SLEEP;

  // Reset-cause flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      if (wd_timeout) begin
        timeout_flag_n <= 1'b0;
      end else if (do_sleep || do_clrwd) begin
        timeout_flag_n <= 1'b1;
      end
      if (do_sleep) begin
        powerdown_flag_n <= 1'b0;
      end else if (do_clrwd) begin
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  // Option register: write-only from software, preset on every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_prescale_options <= SWR_OPTIONS_RST;
    end else if (state_r == SWR_RESET) begin
      timer_prescale_options <= SWR_OPTIONS_RST;
    end else if (wr_en && wr_addr == SWR_OPTIONS_OFF && wr_strb[0]) begin
      timer_prescale_options <= wr_data[7:0] & SWR_OPTIONS_MASK;
    end
  end

  // I/O hold: capture drive state when sleep starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_out_hold_r <= '0;
      io_oe_hold_r <= '0;
    end else if (do_sleep) begin
      io_out_hold_r <= io_out_core;
      io_oe_hold_r <= io_oe_core;
    end
  end
  assign io_out = asleep ? io_out_hold_r : io_out_core;
  assign io_oe = asleep ? io_oe_hold_r : io_oe_core;

  // Interrupt status: sticky events, cleared on read, set wins
  assign ev[SWR_EV_WDT] = wd_timeout;
  assign ev[SWR_EV_WAKE] = wake;
  assign ev[SWR_EV_SLEEP] = do_sleep;
  assign stat_rd = rd_en && rd_addr == SWR_IRQ_STAT_OFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | ev;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= '0;
    end else if (wr_en && wr_addr == SWR_IRQ_MASK_OFF && wr_strb[0]) begin
      irq_mask_r <= wr_data[SWR_EV_W-1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (rd_addr == SWR_STATUS_OFF) begin
      rd_data[SWR_ST_TIMEOUT_BIT] = timeout_flag_n;
      rd_data[SWR_ST_PWRDN_BIT] = powerdown_flag_n;
      rd_data[SWR_ST_ASLEEP_BIT] = asleep;
    end else if (rd_addr == SWR_IRQ_STAT_OFF) begin
      rd_data[SWR_EV_W-1:0] = irq_stat_r;
    end else if (rd_addr == SWR_IRQ_MASK_OFF) begin
      rd_data[SWR_EV_W-1:0] = irq_mask_r;
    end else if (rd_addr == SWR_OPTIONS_OFF || rd_addr == SWR_CTRL_OFF) begin
      rd_data = 32'h0000_0000;
    end else begin
      rd_err = 1'b1;
    end
  end
  assign wr_err = !(wr_addr == SWR_OPTIONS_OFF || wr_addr == SWR_IRQ_MASK_OFF
                    || wr_addr == SWR_CTRL_OFF || wr_addr == SWR_STATUS_OFF
                    || wr_addr == SWR_IRQ_STAT_OFF);

  // Assertions
  sequence s_sleep_cmd;
    do_sleep;
  endsequence
  sequence s_in_sleep;
    state_r == SWR_SLEEP;
  endsequence
  property p_sleep_entry;
    @(posedge aclk) disable iff (!aresetn)
      s_sleep_cmd |=> s_in_sleep ##0 !powerdown_flag_n ##0 !osc_drive_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
  property p_only_cmd;
    @(posedge aclk) disable iff (!aresetn)
      $rose(asleep) |-> $past(sleep_instr || sw_sleep);
  endproperty
  a_only_cmd: assert property (p_only_cmd) else $error("sleep without command");
  property p_io_hold;
    @(posedge aclk) disable iff (!aresetn)
      asleep && $past(asleep) |-> $stable(io_out) && $stable(io_oe);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("pins changed in sleep");
  property p_wake_reset;
    @(posedge aclk) disable iff (!aresetn)
      asleep && (master_clear_pin_n_act || wd_timeout) |=> device_reset && !asleep;
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("wake without reset");
  property p_wdt_reset;
    @(posedge aclk) disable iff (!aresetn)
      state_r == SWR_RUN && wd_timeout |=> device_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");
  property p_to_flag;
    @(posedge aclk) disable iff (!aresetn)
      wd_timeout |=> !timeout_flag_n;
  endproperty
  a_to_flag: assert property (p_to_flag) else $error("timeout flag not cleared");
  property p_wake_clear;
    @(posedge aclk) disable iff (!aresetn)
      wake |=> wd_count == 32'h0000_0000;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("watchdog not cleared");
  property p_opt_reset;
    @(posedge aclk) disable iff (!aresetn)
      device_reset |=> timer_prescale_options == SWR_OPTIONS_RST;
  endproperty
  a_opt_reset: assert property (p_opt_reset) else $error("option not preset");
  property p_wdt_off;
    @(posedge aclk) disable iff (!aresetn)
      !watchdog_enable_cfg |=> !wd_timeout;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("timeout while disabled");
  property p_clrwd;
    @(posedge aclk) disable iff (!aresetn)
      do_clrwd |=> wd_count == 32'h0000_0000 ##1 !wd_timeout;
  endproperty
  a_clrwd: assert property (p_clrwd) else $error("clear watchdog failed");
endmodule : swr_top

/* File: testbench/swr_far_model.sv */
// Far-side model: instruction decoder command pulses and the external reset pin.
// Assumes the bench raises one-cycle request levels just after a rising edge.
`timescale 1ns/1ps
module swr_far_model (
  input wire logic aclk, // System clock
  input wire logic req_sleep, // Ask for a sleep command
  input wire logic req_clrwd, // Ask for a clear-watchdog command
  input wire logic req_master_clear_pin_n, // Hold the reset pin active
  output logic sleep_instr, // Sleep command pulse
  output logic clear_watchdog_instr, // Clear-watchdog command pulse
  output logic master_clear_pin_n // Reset pin, pulled up when idle
);
  // Decoder issues commands edge-aligned; pin low only while asked
  always @(posedge aclk) begin
    sleep_instr <= req_sleep;
    clear_watchdog_instr <= req_clrwd;
    master_clear_pin_n <= ~req_master_clear_pin_n;
  end
endmodule : swr_far_model

/* File: testbench/sleep_wake_reset_cause_tb_top.sv */
// Self-checking bench for the sleep, wake and reset-cause block.
// Assumes a short watchdog base period; the bus master follows AXI4-Lite.
`timescale 1ns/1ps
module sleep_wake_reset_cause_tb_top;
  import swr_pkg::*;
  localparam int WDC = 20;
  logic aclk, aresetn, req_sleep, req_clrwd, req_master_clear_pin_n, cfg;
  logic master_clear_pin_n_n, slp, clrwd, osc, drst, asleep, ton, pdn, irq;
  logic [7:0] ioc, ioec, io_out, io_oe, opts, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int seed, error_cnt, tests_run, n, k;
  logic [7:0] eo, ee;

  swr_far_model i_far (.aclk(aclk), .req_sleep(req_sleep), .req_clrwd(req_clrwd),
    .req_master_clear_pin_n(req_master_clear_pin_n), .sleep_instr(slp), .clear_watchdog_instr(clrwd),
    .master_clear_pin_n(master_clear_pin_n_n));

  swr_top #(.WDT_CYCLES(WDC), .IO_W(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .master_clear_pin_n(master_clear_pin_n_n), .sleep_instr(slp), .clear_watchdog_instr(clrwd),
    .watchdog_enable_cfg(cfg), .io_out_core(ioc), .io_oe_core(ioec), .io_out(io_out),
    .io_oe(io_oe), .osc_drive_en(osc), .device_reset(drst), .asleep(asleep),
    .timeout_flag_n(ton), .powerdown_flag_n(pdn), .timer_prescale_options(opts),
    .irq(irq), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));

  // Clock generator, 10 ns period
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  // Bus read
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  // Wait, bounded, for the internal reset to reach a level
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (drst !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk(drst, v, "reset level wait");
  endtask : wait_rst

  // Expected watchdog period in cycles for an option value
  function automatic int exp_period(input logic [7:0] opt);
    exp_period = opt[SWR_OPT_ASSIGN_BIT] ? (WDC << opt[2:0]) : WDC;
  endfunction : exp_period

  // One-cycle command request to the far-side model
  task automatic cmd_sleep;
    req_sleep <= 1'b1;
    @(posedge aclk);
    req_sleep <= 1'b0;
  endtask : cmd_sleep

  // Hang guard
  initial begin
    #300us;
    error_cnt++;
    $display("BAD t=%0t run did not finish", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    seed = 37084;
    error_cnt = 0;
    tests_run = 0;
    {aresetn, req_sleep, req_clrwd, req_master_clear_pin_n, cfg} = '0;
    {ioc, ioec, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_rst(1'b0, 50);
    chk({ton, pdn, asleep, osc}, 4'b1101, "power-up flags");
    chk(opts, 8'h3F, "options at power-up");
    axr(SWR_STATUS_OFF);
    chk(d & 32'h19, 32'h18, "status at power-up");
    axr(8'h40);
    chk(r, 2'b10, "unmapped read");
    axr(SWR_OPTIONS_OFF);
    chk(d, 32'h0, "options write-only");
    $display("test reset done");
    // Random and boundary option values
    for (k = 0; k < 5; k++) begin
      eo = (k == 4) ? 8'hC0 : 8'($random(seed));
      axw(SWR_OPTIONS_OFF, {24'h0, eo});
      chk(r, 2'b00, "options write resp");
      chk(opts, eo & 8'h3F, "options kept bits");
    end
    $display("test options done");
    // Sleep entry, pin hold, interrupt mask and read-clear
    axw(SWR_IRQ_MASK_OFF, 32'h0);
    eo = 8'($random(seed));
    ee = 8'($random(seed));
    ioc <= eo;
    ioec <= ee;
    repeat (5) @(posedge aclk);
    chk(asleep, 1'b0, "no sleep without command");
    cmd_sleep();
    repeat (3) @(posedge aclk);
    chk({ton, pdn, asleep, osc}, 4'b1010, "sleep entry");
    ioc <= ~eo;
    ioec <= ~ee;
    repeat (3) @(posedge aclk);
    chk({io_out, io_oe}, {eo, ee}, "pins held");
    chk(irq, 1'b0, "masked event");
    axw(SWR_IRQ_MASK_OFF, 32'h4);
    chk(irq, 1'b1, "unmasked event");
    axr(SWR_IRQ_STAT_OFF);
    chk(d & 32'h4, 32'h4, "sleep event bit");
    chk(irq, 1'b0, "read clears");
    repeat (60) @(posedge aclk);
    chk(asleep, 1'b1, "no wake while disabled");
    $display("test sleep done");
    // Wake on the reset pin; sleep command during reset ignored
    req_master_clear_pin_n <= 1'b1;
    wait_rst(1'b1, 10);
    chk({asleep, osc}, 2'b01, "pin wake");
    cmd_sleep();
    repeat (8) @(posedge aclk);
    req_master_clear_pin_n <= 1'b0;
    wait_rst(1'b0, 50);
    chk({ton, pdn, asleep, osc}, 4'b1001, "pin wake cause");
    chk(opts, 8'h3F, "options after pin reset");
    $display("test pin wake done");
    // Clear-watchdog keeps the watchdog from firing
    axw(SWR_OPTIONS_OFF, 32'h0);
    cfg <= 1'b1;
    for (k = 0; k < 12; k++) begin
      req_clrwd <= 1'b1;
      @(posedge aclk);
      req_clrwd <= 1'b0;
      repeat (9) @(posedge aclk);
      chk(drst, 1'b0, "no time-out while cleared");
    end
    chk({ton, pdn}, 2'b11, "clear sets flags");
    wait_rst(1'b1, 40);
    cfg <= 1'b0;
    chk(n >= exp_period(8'h00) - 12 && n <= exp_period(8'h00), 1'b1, "base period");
    wait_rst(1'b0, 50);
    chk({ton, opts}, {1'b0, 8'h3F}, "time-out cause");
    $display("test clear watchdog done");
    // Watchdog wake from sleep with a random postscale ratio
    eo = 8'h08 | 8'($unsigned($random(seed)) % 3);
    axw(SWR_OPTIONS_OFF, {24'h0, eo});
    cfg <= 1'b1;
    cmd_sleep();
    wait_rst(1'b1, 100);
    cfg <= 1'b0;
    chk(n >= exp_period(eo) - 2 && n <= exp_period(eo) + 8, 1'b1, "scaled period");
    wait_rst(1'b0, 50);
    chk({ton, pdn, asleep, osc}, 4'b0001, "watchdog wake cause");
    chk(opts, 8'h3F, "options after watchdog reset");
    $display("test watchdog wake done");
    // Sleep and clear-watchdog through the control register, sticky events
    axw(SWR_CTRL_OFF, 32'h1 << SWR_CTRL_SLEEP_BIT);
    chk(asleep, 1'b1, "register sleep");
    axr(SWR_STATUS_OFF);
    chk(d & 32'h19, 32'h11, "status in sleep");
    req_master_clear_pin_n <= 1'b1;
    wait_rst(1'b1, 10);
    req_master_clear_pin_n <= 1'b0;
    wait_rst(1'b0, 50);
    axw(SWR_CTRL_OFF, 32'h1 << SWR_CTRL_CLRWD_BIT);
    chk({ton, pdn, asleep}, 3'b110, "register clear-watchdog");
    axr(SWR_IRQ_STAT_OFF);
    chk(d, 32'h7, "sticky events");
    axr(SWR_IRQ_STAT_OFF);
    chk(d, 32'h0, "events cleared by read");
    $display("test control register done");
    tally_and_finish();
  end
endmodule : sleep_wake_reset_cause_tb_top
